/* File: iasm_pkg.sv */
// package: operation codes, widths, busy counts and carrier structs of the integer execute unit
package iasm_pkg;
  localparam int IASM_XLEN = 64;
  localparam int IASM_WLEN = 32;
  localparam int IASM_IMMW = 16;
  localparam int IASM_SAW = 5;
  localparam int IASM_WORD_SIGN = 31;
  localparam logic [5:0] IASM_UPPER_OFS = 6'h20;
  // multiply busy cycles and divide busy cycles before the result pair may be read
  localparam int IASM_MUL_BUSY = 1;
  localparam int IASM_DIV_BUSY = 36;
  localparam int IASM_CNTW = 6;

  typedef enum logic [5:0] {
    IASM_NOP,
    IASM_WIDE_SUM_IMM_TRAP, IASM_WIDE_SUM_IMM_WRAP,
    IASM_SUM_TRAP, IASM_SUM_WRAP, IASM_DIFF_TRAP, IASM_DIFF_WRAP,
    IASM_LT_SIGNED, IASM_LT_UNSIGNED,
    IASM_AND, IASM_OR, IASM_XOR, IASM_NOR,
    IASM_WIDE_SUM_TRAP, IASM_WIDE_SUM_WRAP, IASM_WIDE_DIFF_TRAP, IASM_WIDE_DIFF_WRAP,
    IASM_CONST_LEFT, IASM_CONST_RIGHT_LOG, IASM_CONST_RIGHT_ARITH,
    IASM_VAR_LEFT, IASM_VAR_RIGHT_LOG, IASM_VAR_RIGHT_ARITH,
    IASM_WIDE_CONST_LEFT, IASM_WIDE_CONST_RIGHT_LOG, IASM_WIDE_CONST_RIGHT_ARITH,
    IASM_WIDE_VAR_LEFT, IASM_WIDE_VAR_RIGHT_LOG, IASM_WIDE_VAR_RIGHT_ARITH,
    IASM_WIDE_UPPER_LEFT, IASM_WIDE_UPPER_RIGHT_LOG, IASM_WIDE_UPPER_RIGHT_ARITH,
    IASM_PRODUCT_SIGNED, IASM_PRODUCT_UNSIGNED, IASM_QUOTIENT_SIGNED, IASM_QUOTIENT_UNSIGNED,
    IASM_READ_UPPER, IASM_READ_BOTTOM, IASM_WRITE_UPPER, IASM_WRITE_BOTTOM
  } iasm_op_t;

  typedef struct packed {
    logic valid;
    iasm_op_t op;
    logic [IASM_XLEN-1:0] src_a;
    logic [IASM_XLEN-1:0] src_b;
    logic [IASM_IMMW-1:0] imm;
    logic [IASM_SAW-1:0] shamt;
  } iasm_req_t;

  typedef struct packed {
    logic valid;
    logic wr_en;
    logic overflow;
    logic [IASM_XLEN-1:0] data;
  } iasm_rsp_t;
endpackage : iasm_pkg

/* File: iasm_shifter.sv */
// shifter: 64-bit shift left, right logical or right arithmetic by a 6-bit count
`timescale 1ns/1ps
module iasm_shifter
  import iasm_pkg::*;
(
  input wire logic [IASM_XLEN-1:0] val_in,
  input wire logic [5:0] count_in,
  input wire logic left_in,
  input wire logic arith_in,
  output logic [IASM_XLEN-1:0] res_out
);
  always_comb
  begin
    if (left_in)
    begin
      res_out = val_in << count_in;
    end
    else if (arith_in)
    begin
      res_out = $signed(val_in) >>> count_in;
    end
    else
    begin
      res_out = val_in >> count_in;
    end
  end
endmodule : iasm_shifter

/* File: iasm_alu.sv */
// top: integer execute unit with adds, compares, logic, shifts, multiply, divide and result pair
`timescale 1ns/1ps
module iasm_alu
  import iasm_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire iasm_req_t req_in,
  output logic req_ready_out,
  output iasm_rsp_t rsp_out,
  output logic [IASM_XLEN-1:0] upper_out,
  output logic [IASM_XLEN-1:0] bottom_out
);
  typedef struct packed {
    iasm_rsp_t rsp;
    logic [IASM_XLEN-1:0] upper;
    logic [IASM_XLEN-1:0] bottom;
    logic [IASM_CNTW-1:0] busy;
    logic ready;
  } iasm_state_t;

  iasm_state_t st_r;
  iasm_state_t st_nxt;

  logic [IASM_XLEN-1:0] a;
  logic [IASM_XLEN-1:0] b;
  logic [IASM_XLEN-1:0] imm_sx;
  logic [IASM_XLEN-1:0] wsum;
  logic [IASM_XLEN-1:0] wdiff;
  logic [IASM_XLEN-1:0] isum;
  logic [IASM_WLEN-1:0] sum32;
  logic [IASM_WLEN-1:0] diff32;
  logic [IASM_XLEN-1:0] sh_val;
  logic [5:0] sh_cnt;
  logic sh_left;
  logic sh_arith;
  logic [IASM_XLEN-1:0] sh_res;
  logic [IASM_XLEN-1:0] prod;
  logic [IASM_WLEN-1:0] quo;
  logic [IASM_WLEN-1:0] rem;
  logic take;
  logic pair_read;

  assign a = req_in.src_a;
  assign b = req_in.src_b;
  assign imm_sx = {{(IASM_XLEN-IASM_IMMW){req_in.imm[IASM_IMMW-1]}}, req_in.imm};
  assign isum = a + imm_sx;
  assign wsum = a + b;
  assign wdiff = a - b;
  assign sum32 = a[IASM_WLEN-1:0] + b[IASM_WLEN-1:0];
  assign diff32 = a[IASM_WLEN-1:0] - b[IASM_WLEN-1:0];

  function automatic logic [IASM_XLEN-1:0] sx32(input logic [IASM_WLEN-1:0] v);
    sx32 = {{IASM_WLEN{v[IASM_WORD_SIGN]}}, v};
  endfunction : sx32

  // shifter operand selection
  always_comb
  begin
    sh_left = 1'b0;
    sh_arith = 1'b0;
    sh_val = b;
    sh_cnt = {1'b0, req_in.shamt};
    unique case (req_in.op)
      IASM_CONST_LEFT, IASM_VAR_LEFT, IASM_WIDE_CONST_LEFT, IASM_WIDE_VAR_LEFT, IASM_WIDE_UPPER_LEFT:
      begin
        sh_left = 1'b1;
      end
      IASM_CONST_RIGHT_ARITH, IASM_VAR_RIGHT_ARITH, IASM_WIDE_CONST_RIGHT_ARITH,
      IASM_WIDE_VAR_RIGHT_ARITH, IASM_WIDE_UPPER_RIGHT_ARITH:
      begin
        sh_arith = 1'b1;
      end
      default:
      begin
        sh_left = 1'b0;
      end
    endcase
    unique case (req_in.op)
      IASM_CONST_RIGHT_LOG, IASM_VAR_RIGHT_LOG:
      begin
        sh_val = {{IASM_WLEN{1'b0}}, b[IASM_WLEN-1:0]};
      end
      IASM_CONST_RIGHT_ARITH, IASM_VAR_RIGHT_ARITH:
      begin
        sh_val = sx32(b[IASM_WLEN-1:0]);
      end
      default:
      begin
        sh_val = b;
      end
    endcase
    unique case (req_in.op)
      IASM_VAR_LEFT, IASM_VAR_RIGHT_LOG, IASM_VAR_RIGHT_ARITH:
      begin
        sh_cnt = {1'b0, a[IASM_SAW-1:0]};
      end
      IASM_WIDE_VAR_LEFT, IASM_WIDE_VAR_RIGHT_LOG, IASM_WIDE_VAR_RIGHT_ARITH:
      begin
        sh_cnt = a[IASM_SAW:0];
      end
      IASM_WIDE_UPPER_LEFT, IASM_WIDE_UPPER_RIGHT_LOG, IASM_WIDE_UPPER_RIGHT_ARITH:
      begin
        sh_cnt = IASM_UPPER_OFS + {1'b0, req_in.shamt};
      end
      default:
      begin
        sh_cnt = {1'b0, req_in.shamt};
      end
    endcase
  end

  iasm_shifter u_shifter (
    .val_in(sh_val),
    .count_in(sh_cnt),
    .left_in(sh_left),
    .arith_in(sh_arith),
    .res_out(sh_res)
  );

  // word multiply and divide
  always_comb
  begin
    prod = '0;
    quo = '0;
    rem = '0;
    if (req_in.op == IASM_PRODUCT_SIGNED)
    begin
      prod = IASM_XLEN'($signed(a[IASM_WLEN-1:0]) * $signed(b[IASM_WLEN-1:0]));
    end
    else
    begin
      prod = IASM_XLEN'({{IASM_WLEN{1'b0}}, a[IASM_WLEN-1:0]} * {{IASM_WLEN{1'b0}}, b[IASM_WLEN-1:0]});
    end
    if (b[IASM_WLEN-1:0] != '0)
    begin
      if (req_in.op == IASM_QUOTIENT_SIGNED)
      begin
        quo = IASM_WLEN'($signed(a[IASM_WLEN-1:0]) / $signed(b[IASM_WLEN-1:0]));
        rem = IASM_WLEN'($signed(a[IASM_WLEN-1:0]) % $signed(b[IASM_WLEN-1:0]));
      end
      else
      begin
        quo = a[IASM_WLEN-1:0] / b[IASM_WLEN-1:0];
        rem = a[IASM_WLEN-1:0] % b[IASM_WLEN-1:0];
      end
    end
  end

  assign pair_read = req_in.op == IASM_READ_UPPER || req_in.op == IASM_READ_BOTTOM;
  // a pair read waits while a multiply or divide is still busy
  assign take = req_in.valid && !(pair_read && st_r.busy != '0);

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rsp = '0;
    if (st_r.busy != '0)
    begin
      st_nxt.busy = st_r.busy - 1'b1;
    end
    if (take)
    begin
      st_nxt.rsp.valid = 1'b1;
      st_nxt.rsp.wr_en = 1'b1;
      unique case (req_in.op)
        IASM_NOP:
        begin
          st_nxt.rsp.valid = 1'b0;
          st_nxt.rsp.wr_en = 1'b0;
        end
        IASM_WIDE_SUM_IMM_TRAP, IASM_WIDE_SUM_IMM_WRAP:
        begin
          st_nxt.rsp.data = isum;
          st_nxt.rsp.overflow = (req_in.op == IASM_WIDE_SUM_IMM_TRAP) &&
            (a[IASM_XLEN-1] == imm_sx[IASM_XLEN-1]) && (isum[IASM_XLEN-1] != a[IASM_XLEN-1]);
        end
        IASM_SUM_TRAP, IASM_SUM_WRAP:
        begin
          st_nxt.rsp.data = sx32(sum32);
          st_nxt.rsp.overflow = (req_in.op == IASM_SUM_TRAP) && (a[IASM_WORD_SIGN] == b[IASM_WORD_SIGN]) &&
            (sum32[IASM_WORD_SIGN] != a[IASM_WORD_SIGN]);
        end
        IASM_DIFF_TRAP, IASM_DIFF_WRAP:
        begin
          st_nxt.rsp.data = sx32(diff32);
          st_nxt.rsp.overflow = (req_in.op == IASM_DIFF_TRAP) && (a[IASM_WORD_SIGN] != b[IASM_WORD_SIGN]) &&
            (diff32[IASM_WORD_SIGN] != a[IASM_WORD_SIGN]);
        end
        IASM_LT_SIGNED:
        begin
          st_nxt.rsp.data = {63'h0, $signed(a) < $signed(b)};
        end
        IASM_LT_UNSIGNED:
        begin
          st_nxt.rsp.data = {63'h0, a < b};
        end
        IASM_AND:
        begin
          st_nxt.rsp.data = a & b;
        end
        IASM_OR:
        begin
          st_nxt.rsp.data = a | b;
        end
        IASM_XOR:
        begin
          st_nxt.rsp.data = a ^ b;
        end
        IASM_NOR:
        begin
          st_nxt.rsp.data = ~(a | b);
        end
        IASM_WIDE_SUM_TRAP, IASM_WIDE_SUM_WRAP:
        begin
          st_nxt.rsp.data = wsum;
          st_nxt.rsp.overflow = (req_in.op == IASM_WIDE_SUM_TRAP) && (a[IASM_XLEN-1] == b[IASM_XLEN-1]) &&
            (wsum[IASM_XLEN-1] != a[IASM_XLEN-1]);
        end
        IASM_WIDE_DIFF_TRAP, IASM_WIDE_DIFF_WRAP:
        begin
          st_nxt.rsp.data = wdiff;
          st_nxt.rsp.overflow = (req_in.op == IASM_WIDE_DIFF_TRAP) && (a[IASM_XLEN-1] != b[IASM_XLEN-1]) &&
            (wdiff[IASM_XLEN-1] != a[IASM_XLEN-1]);
        end
        IASM_CONST_LEFT, IASM_CONST_RIGHT_LOG, IASM_CONST_RIGHT_ARITH,
        IASM_VAR_LEFT, IASM_VAR_RIGHT_LOG, IASM_VAR_RIGHT_ARITH:
        begin
          st_nxt.rsp.data = sx32(sh_res[IASM_WLEN-1:0]);
        end
        IASM_WIDE_CONST_LEFT, IASM_WIDE_CONST_RIGHT_LOG, IASM_WIDE_CONST_RIGHT_ARITH,
        IASM_WIDE_VAR_LEFT, IASM_WIDE_VAR_RIGHT_LOG, IASM_WIDE_VAR_RIGHT_ARITH,
        IASM_WIDE_UPPER_LEFT, IASM_WIDE_UPPER_RIGHT_LOG, IASM_WIDE_UPPER_RIGHT_ARITH:
        begin
          st_nxt.rsp.data = sh_res;
        end
        IASM_PRODUCT_SIGNED, IASM_PRODUCT_UNSIGNED:
        begin
          st_nxt.rsp.wr_en = 1'b0;
          st_nxt.upper = sx32(prod[IASM_XLEN-1:IASM_WLEN]);
          st_nxt.bottom = sx32(prod[IASM_WLEN-1:0]);
          st_nxt.busy = IASM_CNTW'(IASM_MUL_BUSY);
        end
        IASM_QUOTIENT_SIGNED, IASM_QUOTIENT_UNSIGNED:
        begin
          st_nxt.rsp.wr_en = 1'b0;
          st_nxt.upper = sx32(rem);
          st_nxt.bottom = sx32(quo);
          st_nxt.busy = IASM_CNTW'(IASM_DIV_BUSY);
        end
        IASM_READ_UPPER:
        begin
          st_nxt.rsp.data = st_r.upper;
        end
        IASM_READ_BOTTOM:
        begin
          st_nxt.rsp.data = st_r.bottom;
        end
        IASM_WRITE_UPPER:
        begin
          st_nxt.rsp.wr_en = 1'b0;
          st_nxt.upper = a;
        end
        IASM_WRITE_BOTTOM:
        begin
          st_nxt.rsp.wr_en = 1'b0;
          st_nxt.bottom = a;
        end
      endcase
    end
    st_nxt.ready = (st_nxt.busy == '0);
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      st_r <= '0;
      st_r.ready <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign req_ready_out = st_r.ready;
  assign rsp_out = st_r.rsp;
  assign upper_out = st_r.upper;
  assign bottom_out = st_r.bottom;

  a_read_stall: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    req_in.valid && pair_read && st_r.busy != '0 |=> !rsp_out.valid)
    else $error("pair read answered while busy");
  a_div_busy: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    take && req_in.op == IASM_QUOTIENT_UNSIGNED |=> st_r.busy == IASM_CNTW'(IASM_DIV_BUSY))
    else $error("divide busy count wrong");
  a_wrap_noovf: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    take && (req_in.op == IASM_SUM_WRAP || req_in.op == IASM_WIDE_SUM_IMM_WRAP) |=> !rsp_out.overflow)
    else $error("wrap form raised overflow");
  a_imm_sum: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    take && req_in.op == IASM_WIDE_SUM_IMM_WRAP |=> rsp_out.data == $past(isum))
    else $error("immediate sum wrong");
  a_word_sext: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    $past(take) && $past(req_in.op) == IASM_SUM_WRAP |-> rsp_out.data[63:32] == {32{rsp_out.data[31]}})
    else $error("word result not sign extended");
  a_lt_bool: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    take && req_in.op == IASM_LT_UNSIGNED |=> rsp_out.data == {63'h0, $past(a < b)})
    else $error("compare result wrong");
  a_move_upper: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    take && req_in.op == IASM_WRITE_UPPER |=> upper_out == $past(a))
    else $error("upper write lost");
  a_nor_val: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    take && req_in.op == IASM_NOR |=> rsp_out.data == ~($past(a) | $past(b)))
    else $error("nor result wrong");
endmodule : iasm_alu

/* File: iasm_pipe_model.sv */
// partner model: pipeline side that presents decoded requests to the execute unit
`timescale 1ns/1ps
module iasm_pipe_model
  import iasm_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic req_ready_in,
  output iasm_req_t req_out
);
  initial req_out = '0;
  // holds the request until taken; pair reads are re-presented while busy
  task automatic issue(input iasm_req_t r);
    req_out = r;
    @(posedge ref_clk_in);
    while ((r.op == IASM_READ_UPPER || r.op == IASM_READ_BOTTOM) && req_ready_in !== 1'b1)
      @(posedge ref_clk_in);
    #1;
  endtask : issue
  // released operands are scrambled rather than left at the last value
  task automatic idle();
    req_out.valid = 1'b0;
    req_out.src_a = ~req_out.src_a;
    req_out.src_b = ~req_out.src_b;
  endtask : idle
endmodule : iasm_pipe_model

/* File: iasm_alu_tb.sv */
// testbench: self-checking bench for the integer execute unit
`timescale 1ns/1ps
module iasm_alu_tb;
  import iasm_pkg::*;
  logic ref_clk_in;
  logic rst_b_in;
  iasm_req_t req_in;
  logic req_ready_out;
  iasm_rsp_t rsp_out;
  iasm_rsp_t exp_q[$];
  logic [63:0] up_m;
  logic [63:0] bot_m;
  logic [63:0] upper_out;
  logic [63:0] bottom_out;
  int fails;
  int tests_run;
  int cyc;
  int t0;

  iasm_alu dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .req_in(req_in), .req_ready_out(req_ready_out),
    .rsp_out(rsp_out), .upper_out(upper_out), .bottom_out(bottom_out));
  iasm_pipe_model pipe (.ref_clk_in(ref_clk_in), .req_ready_in(req_ready_out), .req_out(req_in));

  initial
  begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  function automatic logic [63:0] sx(input logic [31:0] w);
    return {{32{w[31]}}, w};
  endfunction : sx

  task automatic err(input string m);
    fails++;
    $display("mismatch %0t %s", $time, m);
  endtask : err

  task automatic test_done();
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  function automatic iasm_rsp_t model(input iasm_req_t r);
    iasm_rsp_t e;
    logic [63:0] a;
    logic [63:0] b;
    logic [63:0] s;
    logic [63:0] im;
    logic [31:0] w;
    logic [31:0] q;
    logic [4:0] ws;
    logic [5:0] ds;
    logic sub;
    e = '{valid: 1'b1, wr_en: 1'b1, overflow: 1'b0, data: '0};
    a = r.src_a;
    b = r.src_b;
    im = {{48{r.imm[15]}}, r.imm};
    sub = r.op inside {IASM_DIFF_TRAP, IASM_DIFF_WRAP, IASM_WIDE_DIFF_TRAP, IASM_WIDE_DIFF_WRAP};
    ws = (r.op inside {[IASM_VAR_LEFT:IASM_VAR_RIGHT_ARITH]}) ? a[4:0] : r.shamt;
    ds = (r.op inside {[IASM_WIDE_VAR_LEFT:IASM_WIDE_VAR_RIGHT_ARITH]}) ? a[5:0] :
      (r.op inside {[IASM_WIDE_UPPER_LEFT:IASM_WIDE_UPPER_RIGHT_ARITH]}) ? 6'h20 + r.shamt : {1'b0, r.shamt};
    case (r.op)
      IASM_WIDE_SUM_IMM_TRAP, IASM_WIDE_SUM_IMM_WRAP, IASM_WIDE_SUM_TRAP, IASM_WIDE_SUM_WRAP,
      IASM_WIDE_DIFF_TRAP, IASM_WIDE_DIFF_WRAP:
      begin
        if (r.op inside {IASM_WIDE_SUM_IMM_TRAP, IASM_WIDE_SUM_IMM_WRAP})
          b = im;
        s = sub ? a - b : a + b;
        e.data = s;
        e.overflow = (r.op inside {IASM_WIDE_SUM_IMM_TRAP, IASM_WIDE_SUM_TRAP, IASM_WIDE_DIFF_TRAP}) &&
          ((a[63] ^ b[63]) == sub) && (s[63] != a[63]);
      end
      IASM_SUM_TRAP, IASM_SUM_WRAP, IASM_DIFF_TRAP, IASM_DIFF_WRAP:
      begin
        w = sub ? a[31:0] - b[31:0] : a[31:0] + b[31:0];
        e.data = sx(w);
        e.overflow = (r.op inside {IASM_SUM_TRAP, IASM_DIFF_TRAP}) && ((a[31] ^ b[31]) == sub) && (w[31] != a[31]);
      end
      IASM_LT_SIGNED: e.data = {63'h0, $signed(a) < $signed(b)};
      IASM_LT_UNSIGNED: e.data = {63'h0, a < b};
      IASM_AND: e.data = a & b;
      IASM_OR: e.data = a | b;
      IASM_XOR: e.data = a ^ b;
      IASM_NOR: e.data = ~(a | b);
      IASM_CONST_LEFT, IASM_VAR_LEFT: e.data = sx(b[31:0] << ws);
      IASM_CONST_RIGHT_LOG, IASM_VAR_RIGHT_LOG: e.data = sx(b[31:0] >> ws);
      IASM_CONST_RIGHT_ARITH, IASM_VAR_RIGHT_ARITH: e.data = sx($signed(b[31:0]) >>> ws);
      IASM_WIDE_CONST_LEFT, IASM_WIDE_VAR_LEFT, IASM_WIDE_UPPER_LEFT: e.data = b << ds;
      IASM_WIDE_CONST_RIGHT_LOG, IASM_WIDE_VAR_RIGHT_LOG, IASM_WIDE_UPPER_RIGHT_LOG: e.data = b >> ds;
      IASM_WIDE_CONST_RIGHT_ARITH, IASM_WIDE_VAR_RIGHT_ARITH, IASM_WIDE_UPPER_RIGHT_ARITH: e.data = $signed(b) >>> ds;
      IASM_PRODUCT_SIGNED, IASM_PRODUCT_UNSIGNED:
      begin
        s = (r.op == IASM_PRODUCT_SIGNED) ? sx(a[31:0]) * sx(b[31:0]) : {32'h0, a[31:0]} * {32'h0, b[31:0]};
        up_m = sx(s[63:32]);
        bot_m = sx(s[31:0]);
        e.wr_en = 1'b0;
      end
      IASM_QUOTIENT_SIGNED, IASM_QUOTIENT_UNSIGNED:
      begin
        // kept apart: a mixed conditional would turn the signed divide unsigned
        if (r.op == IASM_QUOTIENT_SIGNED)
        begin
          q = $signed(a[31:0]) / $signed(b[31:0]);
          w = $signed(a[31:0]) % $signed(b[31:0]);
        end
        else
        begin
          q = a[31:0] / b[31:0];
          w = a[31:0] % b[31:0];
        end
        bot_m = (b[31:0] == 32'h0) ? 64'h0 : sx(q);
        up_m = (b[31:0] == 32'h0) ? 64'h0 : sx(w);
        e.wr_en = 1'b0;
      end
      IASM_READ_UPPER: e.data = up_m;
      IASM_READ_BOTTOM: e.data = bot_m;
      IASM_WRITE_UPPER:
      begin
        up_m = a;
        e.wr_en = 1'b0;
      end
      default:
      begin
        bot_m = a;
        e.wr_en = 1'b0;
      end
    endcase
    return e;
  endfunction : model

  task automatic run(input iasm_op_t op, input logic [63:0] a, input logic [63:0] b, input logic [15:0] imm);
    iasm_req_t r;
    r = '{valid: 1'b1, op: op, src_a: a, src_b: b, imm: imm, shamt: imm[4:0]};
    if (op != IASM_NOP)
      exp_q.push_back(model(r));
    pipe.issue(r);
  endtask : run

  task automatic chk_rsp(input iasm_rsp_t e);
    tests_run++;
    if (rsp_out.wr_en !== e.wr_en || rsp_out.overflow !== e.overflow || (e.wr_en && rsp_out.data !== e.data))
      err($sformatf("response got %h exp %h", rsp_out.data, e.data));
  endtask : chk_rsp

  task automatic chk_pair();
    tests_run++;
    if (upper_out !== up_m || bottom_out !== bot_m)
      err($sformatf("pair got %h %h exp %h %h", upper_out, bottom_out, up_m, bot_m));
  endtask : chk_pair

  task automatic chk_wait(input int got, input int want);
    tests_run++;
    if (got != want)
      err($sformatf("pair read waited %0d cycles, exp %0d", got, want));
  endtask : chk_wait

  // watcher: each response is matched against the oldest note
  always @(negedge ref_clk_in)
    if (rst_b_in && rsp_out.valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        err("unexpected response");
      else
        chk_rsp(exp_q.pop_front());
    end

  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err("timeout");
      test_done();
    end
  end

  initial
  begin
    rst_b_in = 1'b0;
    up_m = '0;
    bot_m = '0;
    void'($urandom(77));
    repeat (20) @(posedge ref_clk_in);
    #1 rst_b_in = 1'b1;
    chk_pair();
    run(IASM_SUM_TRAP, 64'h7fffffff, 64'h1, 16'h0);
    run(IASM_SUM_WRAP, 64'h7fffffff, 64'h1, 16'h0);
    run(IASM_DIFF_TRAP, 64'hffffffff80000000, 64'h1, 16'h0);
    run(IASM_DIFF_WRAP, 64'hffffffff80000000, 64'h1, 16'h0);
    run(IASM_WIDE_SUM_IMM_TRAP, 64'h7fffffffffffffff, 64'h0, 16'h1);
    run(IASM_WIDE_SUM_IMM_WRAP, 64'h7fffffffffffffff, 64'h0, 16'h1);
    run(IASM_WIDE_SUM_IMM_TRAP, 64'h0, 64'h0, 16'h8000);
    run(IASM_WIDE_DIFF_TRAP, 64'h8000000000000000, 64'h1, 16'h0);
    run(IASM_LT_SIGNED, '1, 64'h1, 16'h0);
    run(IASM_LT_UNSIGNED, '1, 64'h1, 16'h0);
    run(IASM_WIDE_UPPER_RIGHT_ARITH, 64'h8000000000000000, 64'h8000000000000000, 16'h1f);
    run(IASM_QUOTIENT_SIGNED, 64'hfffffffffffffff9, 64'h2, 16'h0);
    chk_pair();
    t0 = cyc;
    run(IASM_READ_UPPER, 64'h0, 64'h0, 16'h0);
    chk_wait(cyc - t0, IASM_DIV_BUSY + 1);
    run(IASM_PRODUCT_SIGNED, 64'hfffffffffffffffd, 64'h7fffffff, 16'h0);
    chk_pair();
    t0 = cyc;
    run(IASM_READ_BOTTOM, 64'h0, 64'h0, 16'h0);
    chk_wait(cyc - t0, IASM_MUL_BUSY + 1);
    // an empty slot answers nothing and leaves the pair alone
    run(IASM_NOP, 64'h1, 64'h1, 16'h0);
    chk_pair();
    // every operation but IASM_NOP back to back; word operations get sign-extended operands
    repeat (8)
      for (int k = IASM_WIDE_SUM_IMM_TRAP; k <= IASM_WRITE_BOTTOM; k++)
      begin
        if (iasm_op_t'(k) inside {[IASM_SUM_TRAP:IASM_DIFF_WRAP], [IASM_CONST_LEFT:IASM_VAR_RIGHT_ARITH],
          [IASM_PRODUCT_SIGNED:IASM_QUOTIENT_UNSIGNED]})
          run(iasm_op_t'(k), sx($urandom), sx($urandom), 16'($urandom));
        else
          run(iasm_op_t'(k), {$urandom, $urandom}, {$urandom, $urandom}, 16'($urandom));
        if (k >= IASM_PRODUCT_SIGNED)
          chk_pair();
      end
    pipe.idle();
    repeat (5) @(posedge ref_clk_in);
    if (exp_q.size() != 0)
      err("responses missing");
    test_done();
  end
endmodule : iasm_alu_tb
